// ---- verilog/plpw_power_wakeup.sv ----
`timescale 1ns/1ns
`include "plpw_defines.svh"
module plpw_power_wakeup #(
  parameter int WAKE_CYCLES = `PLPW_WAKE_CYCLES,
  parameter int INIT_CYCLES = `PLPW_INIT_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic aon_clk_in,
  input wire logic aon_srst_in,
  input wire logic link_power_status_in,
  input wire logic link_controller_active_bit_in,
  input wire logic port_disconnected_in,
  input wire logic port_disabled_in,
  input wire logic port_suspended_in,
  input wire logic port_int_enable_in,
  input wire logic port_event_in,
  input wire logic link_on_packet_in,
  input wire logic phy_interrupt_in,
  input wire logic bus_reset_in,
  output logic link_on_request_out,
  output logic interface_clock_out,
  output logic clock_gen_enable_out,
  output logic deep_sleep_out,
  output logic interface_ready_out
);
  ////////////////////////////////////////////////////////////////////////////
  // always-on domain: status and port signals from pins, two flops each
  logic [7:0] aon_s1_reg;
  logic [7:0] aon_s2_reg;
  logic [7:0] aon_s1_next;
  logic [7:0] aon_s2_next;
  logic lps_a;
  logic disc_a;
  logic dis_a;
  logic susp_a;
  logic pie_a;
  logic pev_a;
  plpw_pkg::plpw_state_t st_reg;
  plpw_pkg::plpw_state_t st_next;
  logic [22:0] wcnt_reg;
  logic [22:0] wcnt_next;
  logic gen_en_reg;
  logic gen_en_next;
  logic deep_reg;
  logic deep_next;
  logic ready_reg;
  logic ready_next;
  logic [22:0] wake_lim;
  logic [22:0] init_lim;

  assign wake_lim = 23'(WAKE_CYCLES);
  assign init_lim = 23'(INIT_CYCLES);

  always_comb begin
    aon_s1_next = {2'h0, port_event_in, port_int_enable_in, port_suspended_in,
                   port_disabled_in, port_disconnected_in, link_power_status_in};
    aon_s2_next = aon_s1_reg;
  end

  always_ff @(posedge aon_clk_in) begin
    aon_s1_reg <= aon_s1_next;
    aon_s2_reg <= aon_s2_next;
  end

  assign lps_a = aon_s2_reg[0];
  assign disc_a = aon_s2_reg[1];
  assign dis_a = aon_s2_reg[2];
  assign susp_a = aon_s2_reg[3];
  assign pie_a = aon_s2_reg[4];
  assign pev_a = aon_s2_reg[5];

  ////////////////////////////////////////////////////////////////////////////
  // power sequencer, on the always-on clock since the generators stop
  always_comb begin
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    gen_en_next = gen_en_reg;
    deep_next = 1'b0;
    ready_next = 1'b0;
    case (st_reg)
      plpw_pkg::PLPW_ACTIVE: begin
        gen_en_next = 1'b1;
        ready_next = 1'b1;
        if (!lps_a) begin
          st_next = plpw_pkg::PLPW_IF_DISABLED;
          ready_next = 1'b0;
        end
      end
      plpw_pkg::PLPW_IF_DISABLED: begin
        gen_en_next = 1'b1;
        if (lps_a) begin
          st_next = plpw_pkg::PLPW_IF_INIT;
          wcnt_next = 23'h0;
        end else if (disc_a || dis_a || susp_a) begin
          st_next = plpw_pkg::PLPW_LOW_POWER;
          gen_en_next = 1'b0;
          // deep flag moves with the generator enable so both cross together
          deep_next = disc_a || (dis_a && !pie_a);
        end
      end
      plpw_pkg::PLPW_LOW_POWER: begin
        gen_en_next = 1'b0;
        deep_next = disc_a || (dis_a && !pie_a);
        if (lps_a || pev_a || !(disc_a || dis_a || susp_a)) begin
          st_next = plpw_pkg::PLPW_WAKING;
          gen_en_next = 1'b1;
          wcnt_next = 23'h0;
          deep_next = 1'b0;
        end
      end
      plpw_pkg::PLPW_WAKING: begin
        // generators settle; bounded so the interface is up in time
        gen_en_next = 1'b1;
        wcnt_next = wcnt_reg + 23'h1;
        if (wcnt_reg + init_lim + 23'h2 >= wake_lim) begin
          st_next = lps_a ? plpw_pkg::PLPW_IF_INIT : plpw_pkg::PLPW_IF_DISABLED;
          wcnt_next = 23'h0;
        end
      end
      plpw_pkg::PLPW_IF_INIT: begin
        gen_en_next = 1'b1;
        wcnt_next = wcnt_reg + 23'h1;
        if (!lps_a) begin
          st_next = plpw_pkg::PLPW_IF_DISABLED;
        end else if (wcnt_reg >= init_lim) begin
          st_next = plpw_pkg::PLPW_ACTIVE;
          ready_next = 1'b1;
        end
      end
      default: begin
        st_next = plpw_pkg::PLPW_IF_DISABLED;
      end
    endcase
  end

  always_ff @(posedge aon_clk_in) begin
    if (aon_srst_in) begin
      st_reg <= plpw_pkg::PLPW_IF_DISABLED;
      wcnt_reg <= 23'h0;
      gen_en_reg <= 1'b1;
      deep_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      wcnt_reg <= wcnt_next;
      gen_en_reg <= gen_en_next;
      deep_reg <= deep_next;
      ready_reg <= ready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ref clock domain: levels from the always-on side and the wake/bus reset pins, two flops each
  logic [3:0] r_s1_reg;
  logic [3:0] r_s2_reg;
  logic [3:0] r_s1_next;
  logic [3:0] r_s2_next;
  logic [2:0] r_in_s1_reg;
  logic [2:0] r_in_s2_reg;
  logic [2:0] r_in_s1_next;
  logic [2:0] r_in_s2_next;
  logic r_gen;
  logic r_ready;
  logic r_lps;
  logic inactive;
  logic wake_evt;
  logic lkon_reg;
  logic lkon_next;
  logic sq_reg;
  logic sq_next;
  logic [3:0] half_reg;
  logic [3:0] half_next;
  logic clk_div_reg;
  logic clk_div_next;
  logic gen_out_reg;
  logic deep_out_reg;
  logic ready_out_reg;

  always_comb begin
    r_s1_next = {deep_reg, ready_reg, gen_en_reg, lps_a};
    r_s2_next = r_s1_reg;
    r_in_s1_next = {bus_reset_in, phy_interrupt_in, link_on_packet_in};
    r_in_s2_next = r_in_s1_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    r_s1_reg <= r_s1_next;
    r_s2_reg <= r_s2_next;
    r_in_s1_reg <= r_in_s1_next;
    r_in_s2_reg <= r_in_s2_next;
  end

  assign r_lps = r_s2_reg[0];
  assign r_gen = r_s2_reg[1];
  assign r_ready = r_s2_reg[2];
  assign inactive = !r_lps || !link_controller_active_bit_in;
  assign wake_evt = r_in_s2_reg[0] || r_in_s2_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // link-on request and its square wave
  always_comb begin
    lkon_next = lkon_reg;
    if (inactive && wake_evt) begin
      lkon_next = 1'b1;
    end else if (!inactive) begin
      lkon_next = 1'b0;
    end else if (r_in_s2_reg[2] && !r_in_s2_reg[1]) begin
      lkon_next = 1'b0;
    end
    half_next = half_reg + 4'h1;
    sq_next = sq_reg;
    if (!lkon_reg) begin
      half_next = 4'h0;
      sq_next = 1'b0;
    end else if (half_reg >= 4'(`PLPW_LINKON_HALF_CYCLES - 1)) begin
      half_next = 4'h0;
      sq_next = !sq_reg;
    end
    // interface clock only runs while the generators are on
    clk_div_next = r_gen ? !clk_div_reg : 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lkon_reg <= 1'b0;
      sq_reg <= 1'b0;
      half_reg <= 4'h0;
      clk_div_reg <= 1'b0;
      gen_out_reg <= 1'b1;
      deep_out_reg <= 1'b0;
      ready_out_reg <= 1'b0;
    end else begin
      lkon_reg <= lkon_next;
      sq_reg <= sq_next;
      half_reg <= half_next;
      clk_div_reg <= clk_div_next;
      gen_out_reg <= r_gen;
      deep_out_reg <= r_s2_reg[3];
      ready_out_reg <= r_ready;
    end
  end

  assign link_on_request_out = sq_reg;
  assign interface_clock_out = clk_div_reg;
  assign clock_gen_enable_out = gen_out_reg;
  assign deep_sleep_out = deep_out_reg;
  assign interface_ready_out = ready_out_reg;
endmodule : plpw_power_wakeup

// ---- verilog/plpw_defines.svh ----
`ifndef PLPW_DEFINES_SVH
`define PLPW_DEFINES_SVH
// What this block does
// - interface disabled, port inactive: enter low power
// - low power stops internal clock generation
// - deepest sleep: disconnected, or disabled without interrupt
// - wake on status high or port event
// - clock out, interface operative within 7.3 ms
// - status returns while reset/disabled: reinitialise interface
// - link-on output toggles, period about 163 ns
// - link-on starts: inactive controller plus wake event
// - inactive: status low or active bit clear
// - wake event: own link-on packet or interrupt
// - link-on stops once controller active
// - bus reset stops link-on unless interrupt pending
`define PLPW_WAKE_MAX_NS 7300000
`define PLPW_CLK_NS 10
// wake bound is counted on the always-on clock, not the main clock
`define PLPW_AON_CLK_NS 125
`define PLPW_WAKE_CYCLES (`PLPW_WAKE_MAX_NS / `PLPW_AON_CLK_NS)
`define PLPW_INIT_CYCLES 16
`define PLPW_LINKON_HALF_NS 80
`define PLPW_LINKON_HALF_CYCLES (`PLPW_LINKON_HALF_NS / `PLPW_CLK_NS)
`endif

// ---- verilog/plpw_pkg.sv ----
package plpw_pkg;
  typedef enum logic [2:0] {
    PLPW_ACTIVE,
    PLPW_IF_DISABLED,
    PLPW_LOW_POWER,
    PLPW_WAKING,
    PLPW_IF_INIT
  } plpw_state_t;
endpackage : plpw_pkg

// ---- tb/plpw_power_wakeup_chk.sv ----
`timescale 1ns/1ns
module plpw_power_wakeup_chk (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic link_power_status_in,
  input wire logic link_controller_active_bit_in,
  input wire logic phy_interrupt_in,
  input wire logic bus_reset_in,
  input wire logic link_on_request_out,
  input wire logic interface_clock_out,
  input wire logic clock_gen_enable_out,
  input wire logic deep_sleep_out,
  input wire logic interface_ready_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // cycles the controller has looked active; 63 covers both sync stages
  logic [5:0] act_reg;
  always_ff @(posedge ref_clk_in)
    if (srst_in || !(link_power_status_in && link_controller_active_bit_in)) act_reg <= 6'h00;
    else if (act_reg != 6'h3F) act_reg <= act_reg + 6'h01;
  a_clk_off_idle: assert property (!clock_gen_enable_out [*3] |-> !interface_clock_out)
    else $error("interface clock runs with generators off");
  a_deep_gen_off: assert property (deep_sleep_out [*3] |-> !clock_gen_enable_out)
    else $error("deep sleep with generators on");
  a_ready_gen_on: assert property (interface_ready_out |-> clock_gen_enable_out)
    else $error("ready while generators off");
  a_ready_clk_run: assert property (interface_ready_out [*2] |-> $changed(interface_clock_out))
    else $error("interface clock stopped while ready");
  a_linkon_stop: assert property (act_reg == 6'h3F |-> !link_on_request_out)
    else $error("link-on runs with controller active");
  a_linkon_start: assert property ($rose(link_on_request_out) |-> act_reg != 6'h3F)
    else $error("link-on started for active controller");
  a_linkon_half: assert property ($rose(link_on_request_out) && act_reg == 6'h00 |=>
    $stable(link_on_request_out) [*7])
    else $error("link-on half period wrong");
  a_busrst_stop: assert property ((bus_reset_in && !phy_interrupt_in) [*8] |-> !link_on_request_out)
    else $error("link-on survives bus reset");
endmodule : plpw_power_wakeup_chk
bind plpw_power_wakeup plpw_power_wakeup_chk u_chk (.*);

// ---- tb/plpw_llc_model.sv ----
`timescale 1ns/1ns
module plpw_llc_model (
  input wire logic clk_in,
  input wire logic off_in,
  input wire logic up_in,
  input wire logic [3:0] dly_in,
  input wire logic link_on_in,
  output logic status_out,
  output logic active_out
);
  // slow answers count more link-on high cycles before powering up
  logic [4:0] seen;
  always_ff @(posedge clk_in) begin
    if (off_in) begin
      seen <= 5'h00;
      status_out <= 1'h0;
      active_out <= 1'h0;
    end else begin
      if (link_on_in && !seen[4]) seen <= seen + 5'h01;
      if (up_in || seen > {1'h0, dly_in}) begin
        status_out <= 1'h1;
        active_out <= 1'h1;
      end
    end
  end
endmodule : plpw_llc_model

// ---- tb/plpw_power_wakeup_tb.sv ----
`timescale 1ns/1ns
module plpw_power_wakeup_tb;
  localparam int HALF = 8;
  logic ref_clk_in = 1'h0, aon_clk_in = 1'h0, srst_in = 1'h1, aon_srst_in = 1'h1;
  logic port_disconnected_in = 1'h0, port_disabled_in = 1'h0, port_suspended_in = 1'h0;
  logic port_int_enable_in = 1'h0, port_event_in = 1'h0, link_on_packet_in = 1'h0;
  logic phy_interrupt_in = 1'h0, bus_reset_in = 1'h0, llc_off = 1'h1, llc_up = 1'h0;
  logic [3:0] llc_dly = 4'h0;
  logic [2:0] cfg;
  logic link_power_status_in, link_controller_active_bit_in, link_on_request_out;
  logic interface_clock_out, clock_gen_enable_out, deep_sleep_out, interface_ready_out;
  int num_errors = 0, tests_run = 0, per;
  always #5 ref_clk_in = ~ref_clk_in;
  always begin
    #62 aon_clk_in = ~aon_clk_in;
    #63 aon_clk_in = ~aon_clk_in;
  end
  plpw_power_wakeup #(.WAKE_CYCLES(60), .INIT_CYCLES(16)) u_plpw_power_wakeup (.*);
  plpw_llc_model u_plpw_llc_model (.clk_in(ref_clk_in), .off_in(llc_off), .up_in(llc_up),
    .dly_in(llc_dly), .link_on_in(link_on_request_out),
    .status_out(link_power_status_in), .active_out(link_controller_active_bit_in));
  task step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : step
  task chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) step(1);
    chk(s, v);
  endtask : wait_for
  task automatic watch(input logic busy);
    int h = 0;
    repeat (60) begin
      step(1);
      h += link_on_request_out === 1'h1;
    end
    chk(h > 0, busy);
  endtask : watch
  function automatic logic deep_exp(input logic [2:0] p);
    return p[2] | (p[1] & !p[0]);
  endfunction : deep_exp
  task test_done;
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    num_errors++;
    test_done;
  end
  initial begin
    void'($urandom(32'hDBD85983));
    step(2);
    srst_in = 1'h0;
    step(30);
    aon_srst_in = 1'h0;
    chk(clock_gen_enable_out, 1'h1);
    chk(link_on_request_out, 1'h0);
    repeat (3) begin
      cfg = 3'($urandom);
      {port_disconnected_in, port_disabled_in, port_int_enable_in} = cfg;
      port_suspended_in = 1'h1;
      llc_off = 1'h1;
      llc_up = 1'h0;
      wait_for(clock_gen_enable_out, 1'h0, 300);
      step(5);
      chk(deep_sleep_out, deep_exp(cfg));
      chk(interface_clock_out, 1'h0);
      llc_off = 1'h0;
      llc_up = 1'h1;
      wait_for(interface_ready_out, 1'h1, 1100);
    end
    llc_up = 1'h0;
    llc_off = 1'h1;
    wait_for(clock_gen_enable_out, 1'h0, 300);
    port_event_in = 1'h1;
    wait_for(clock_gen_enable_out, 1'h1, 300);
    port_event_in = 1'h0;
    wait_for(clock_gen_enable_out, 1'h0, 1100);
    {port_disconnected_in, port_disabled_in, port_suspended_in} = 3'h0;
    for (int k = 0; k < 2; k++) begin
      llc_up = 1'h0;
      llc_off = 1'h1;
      llc_dly = 4'($urandom);
      step(40);
      link_on_packet_in = k == 0;
      phy_interrupt_in = k == 1;
      step(3 + $urandom_range(5));
      link_on_packet_in = 1'h0;
      wait_for(link_on_request_out, 1'h1, 40);
      per = 0;
      while (link_on_request_out === 1'h1 && per < 40) begin
        step(1);
        per++;
      end
      chk(per == HALF, 1'h1);
      if (k == 0) begin
        llc_off = 1'h0;
        step(200);
        watch(1'h0);
      end else begin
        bus_reset_in = 1'h1;
        watch(1'h1);
        phy_interrupt_in = 1'h0;
        step(10);
        watch(1'h0);
        bus_reset_in = 1'h0;
      end
    end
    test_done;
  end
endmodule : plpw_power_wakeup_tb
